// >>> dv/pdc_core_bench.sv
// Self-checking bench for the duty-limited PWM compensator core
`timescale 1ns/1ps
module pdc_core_bench;
    logic       i_clk, i_rstn, i_reg_we, pull, adc_valid, cs_line;
    logic       o_cs_out, o_cs_oe, o_pwm;
    logic [3:0] i_reg_addr;
    logic [7:0] i_reg_wdata, o_reg_rdata, err, iout, adc_err, v;
    logic [7:0] exp_reg [0:11];
    int         n_mismatch, cmp_count, h, o;

    // ----------------------------------------------------------------
    // Clock, design and far side
    // ----------------------------------------------------------------
    initial i_clk = 1'b0;
    always #2.5 i_clk = ~i_clk;

    pdc_core uut (
        .i_clk(i_clk), .i_rstn(i_rstn), .i_reg_we(i_reg_we),
        .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
        .o_reg_rdata(o_reg_rdata), .i_adc_err(adc_err),
        .i_adc_valid(adc_valid), .i_iout(iout), .i_cs(cs_line),
        .o_cs_out(o_cs_out), .o_cs_oe(o_cs_oe), .o_pwm(o_pwm)
    );
    pdc_far_side far (
        .i_clk(i_clk), .i_err(err), .i_pull(pull), .i_cs_oe(o_cs_oe),
        .i_cs_out(o_cs_out), .o_adc_err(adc_err),
        .o_adc_valid(adc_valid), .o_cs_line(cs_line)
    );

    // ----------------------------------------------------------------
    // Tasks and expectation functions
    // ----------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        cmp_count++;
        if (seen !== want) begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h",
                     $time, seen, want);
        end
    endtask

    // Write strobe is one cycle wide, changed on falling edges
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(negedge i_clk);
        i_reg_we    = 1'b1;
        i_reg_addr  = a;
        i_reg_wdata = d;
        @(negedge i_clk);
        i_reg_we = 1'b0;
    endtask

    // Read data follows the index one edge later
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(negedge i_clk);
        i_reg_addr = a;
        @(negedge i_clk);
        d = o_reg_rdata;
    endtask

    // Any 400-cycle window spans exactly one period of a steady duty
    task automatic measure(output int hi, output int oe);
        hi = 0;
        oe = 0;
        repeat (400) begin
            @(negedge i_clk);
            if (o_pwm === 1'b1) hi++;
            if (o_cs_oe === 1'b1) oe++;
        end
    endtask

    function automatic int on_cycles(input int duty, input int scale);
        on_cycles = 0;
        for (int c = 0; c < 400; c++) if (c * scale < duty * 400) on_cycles++;
    endfunction

    // Only numer0 is live, so the filter reduces to c0*e scaled by 1/256
    function automatic int exp_duty(input int code, input int e,
                                    input int c0, input bit hi, input bit lo);
        int lin;
        lin = (c0 * e) >>> 8;
        if (hi && e > 32) return code * 64;
        if (lo && e < -32) return 0;
        if (lin < 0) return 0;
        return (lin > code * 64) ? code * 64 : lin;
    endfunction

    task automatic run_case(input int code, input int e, input bit hi,
                            input bit lo, input int c0);
        int d;
        wr(4'h1, 8'(c0 >> 8));
        wr(4'h2, 8'(c0));
        wr(4'h0, {6'(code), hi, lo});
        err = 8'(e);
        // Sample, tick and wrap all land inside two periods
        repeat (800) @(negedge i_clk);
        measure(h, o);
        d = exp_duty(code, e, c0, hi, lo);
        check(16'(h), 16'(on_cycles(d, 4096)));
        check(16'(o), 16'(on_cycles(int'(iout), 256)));
        // Status flags follow the saturation side; trim idles at zero
        rd(4'hC, v);
        check(16'(v), 16'({hi && e > 32, lo && e < -32, 6'h00}));
    endtask

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Watchdog against a hang
    initial begin
        repeat (100000) @(posedge i_clk);
        n_mismatch++;
        end_of_test();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        i_rstn = 1'b0;
        i_reg_we = 1'b0;
        i_reg_addr = 4'h0;
        i_reg_wdata = 8'h00;
        err = 8'h00;
        iout = 8'h00;
        pull = 1'b0;
        n_mismatch = 0;
        cmp_count = 0;
        void'($urandom(32'hd99628ad));
        repeat (2) @(negedge i_clk);
        i_rstn = 1'b1;
        // Reset contents of the limit register and every coefficient
        rd(4'h0, v);
        check(16'(v), 16'h00E8);
        for (int i = 1; i < 12; i++) begin
            rd(4'(i), v);
            check(16'(v), 16'h0000);
        end
        // Random fill of every coefficient and the limit register
        for (int i = 0; i < 12; i++) begin
            exp_reg[i] = 8'($urandom);
            wr(4'(i), exp_reg[i]);
        end
        wr(4'hD, 8'hA5);
        for (int i = 0; i < 12; i++) begin
            rd(4'(i), v);
            check(16'(v), 16'(exp_reg[i]));
        end
        rd(4'hD, v);
        check(16'(v), 16'h0000);
        for (int i = 1; i < 12; i++) wr(4'(i), 8'h00);
        // Saturation and window edges with an inverting unit gain
        run_case(58, 33, 1, 0, -256);
        run_case(58, 32, 1, 0, -256);
        run_case(58, -33, 0, 0, -256);
        run_case(58, -33, 0, 1, -256);
        run_case(58, -32, 0, 1, -256);
        run_case(58, -33, 1, 1, -256);
        run_case(63, 100, 1, 1, -256);
        run_case(0, 33, 1, 0, -256);
        // Random ceilings against a high-gain linear path
        for (int k = 0; k < 6; k++) begin
            iout = 8'($urandom);
            run_case($urandom_range(63, 0), int'($urandom_range(64, 0)) - 32,
                     1'($urandom), 1'($urandom), -32768);
        end
        // Share line held low by the other unit raises the trim
        wr(4'h1, 8'h00);
        wr(4'h2, 8'h00);
        wr(4'h0, 8'hE8); // Saturation off while trimming
        err = 8'h00;
        iout = 8'h10;
        pull = 1'b1;
        repeat (16000) @(negedge i_clk);
        rd(4'hC, v);
        check(16'(v[4:0]), 16'h001F);
        measure(h, o);
        check(16'(h), 16'(on_cycles(31, 4096)));
        check(16'(o_cs_out), 16'h0000);
        pull = 1'b0;
        repeat (16000) @(negedge i_clk);
        rd(4'hC, v);
        check(16'(v[4:0]), 16'h0000);
        end_of_test();
    end
endmodule // pdc_core_bench

// >>> dv/pdc_far_side.sv
// Far-side model: output-error ADC and one paralleled unit on the share line
`timescale 1ns/1ps
module pdc_far_side (
    input  wire logic       i_clk,
    input  wire logic [7:0] i_err,
    input  wire logic       i_pull,
    input  wire logic       i_cs_oe,
    input  wire logic       i_cs_out,
    output logic      [7:0] o_adc_err,
    output logic            o_adc_valid,
    output wire logic       o_cs_line
);
    logic [3:0] tmr_q;

    // ----------------------------------------------------------------
    // ADC sample every 16 cycles
    // ----------------------------------------------------------------
    initial begin
        tmr_q       = 4'h0;
        o_adc_valid = 1'b0;
        o_adc_err   = 8'h00;
    end
    // Between samples the bus shows the inverse, so a stray capture shows
    always @(negedge i_clk) begin
        tmr_q       <= tmr_q + 4'h1;
        o_adc_valid <= (tmr_q == 4'hF);
        o_adc_err   <= (tmr_q == 4'hF) ? i_err : ~i_err;
    end

    // Open-drain line with pull-up; the other unit may hold it low
    assign o_cs_line = ~((i_cs_oe & ~i_cs_out) | i_pull);
endmodule // pdc_far_side

// >>> logic/pdc_cfg.svh
// Constants of the duty-limited PWM compensator core
`ifndef PDC_CFG_SVH
`define PDC_CFG_SVH
// Register indices on the internal register port
`define PDC_IDX_LIMIT      4'h0
`define PDC_IDX_NUMER_BASE 4'h1
`define PDC_IDX_DENOM_BASE 4'h9
`define PDC_IDX_STATUS     4'hC
// Limit register layout and reset values of the limit and coefficient registers
`define PDC_LIM_CEIL_MSB   7
`define PDC_LIM_CEIL_LSB   2
`define PDC_LIM_HI_BIT     1
`define PDC_LIM_LO_BIT     0
`define PDC_LIM_RESET      8'hE8
`define PDC_NUMER_RESET    16'h0000
`define PDC_DENOM_RESET    8'h00
// Timing: switching period in ns and clock period in ns
`define PDC_SW_PERIOD_NS   2000
`define PDC_CLK_PERIOD_NS  5
`define PDC_PERIOD_CYC     9'((`PDC_SW_PERIOD_NS) / (`PDC_CLK_PERIOD_NS))
// Compensator scaling and saturation window
`define PDC_COEF_SHIFT     8
`define PDC_SAT_WIN        8'h20
// Current share trim
`define PDC_TRIM_MAX       5'h1F
`define PDC_SHARE_MARGIN   9'h004
`endif

// >>> logic/pdc_core.sv
// Duty-limited third-order PWM compensator with saturation and sharing
//
// Operation
// - Ceiling code in limit bits 7:2 caps duty at code/64.
// - Limit bit 1 enables high-side saturation feedforward.
// - Limit bit 0 enables low-side saturation feedforward.
// - Saturation forces duty to zero or ceiling by transient sign.
// - Inside the window duty follows the compensator gradually.
// - Outside the window duty reaches its limit within one cycle.
// - Compensator is third order, integrator pole and low-pass pole.
// - Four numerator and three denominator coefficients set the filter.
// - Numerators are upper/lower byte pairs, denominators single bytes.
// - Share line exchange drives paralleled output currents equal.
`timescale 1ns/1ps
`include "pdc_cfg.svh"
module pdc_core
    import pdc_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_rstn,
    input  wire logic       i_reg_we,
    input  wire logic [3:0] i_reg_addr,
    input  wire logic [7:0] i_reg_wdata,
    output logic      [7:0] o_reg_rdata,
    input  wire logic [7:0] i_adc_err,
    input  wire logic       i_adc_valid,
    input  wire logic [7:0] i_iout,
    input  wire logic       i_cs,
    output logic            o_cs_out,
    output logic            o_cs_oe,
    output logic            o_pwm
);
    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [7:0] limit_q;
    pdc_numer_t numer_q [4];
    pdc_denom_t denom_q [3];
    logic [7:0] rdata_q;
    logic [5:0] duty_ceiling_code;
    logic       high_sat_feedforward_en;
    logic       low_sat_feedforward_en;
    logic       sat_hi_q;
    logic       sat_lo_q;
    logic [4:0] trim_q;

    assign duty_ceiling_code =
        limit_q[`PDC_LIM_CEIL_MSB:`PDC_LIM_CEIL_LSB];
    assign high_sat_feedforward_en = limit_q[`PDC_LIM_HI_BIT];
    assign low_sat_feedforward_en  = limit_q[`PDC_LIM_LO_BIT];

    // Host writes from the serial front end land here
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            limit_q <= `PDC_LIM_RESET;
            for (int k = 0; k < 4; k++) numer_q[k] <= `PDC_NUMER_RESET;
            for (int k = 0; k < 3; k++) denom_q[k] <= `PDC_DENOM_RESET;
        end else if (i_reg_we) begin
            if (i_reg_addr == `PDC_IDX_LIMIT) begin
                limit_q <= i_reg_wdata;
            end
            for (int k = 0; k < 4; k++) begin
                if (i_reg_addr == `PDC_IDX_NUMER_BASE + 4'(2*k)) begin
                    numer_q[k][15:8] <= i_reg_wdata;
                end
                if (i_reg_addr == `PDC_IDX_NUMER_BASE + 4'(2*k+1)) begin
                    numer_q[k][7:0] <= i_reg_wdata;
                end
            end
            for (int k = 0; k < 3; k++) begin
                if (i_reg_addr == `PDC_IDX_DENOM_BASE + 4'(k)) begin
                    denom_q[k] <= i_reg_wdata;
                end
            end
        end
    end

    // Read mux; unmapped indices read zero
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= '0;
            if (i_reg_addr == `PDC_IDX_LIMIT) rdata_q <= limit_q;
            if (i_reg_addr == `PDC_IDX_STATUS) begin
                rdata_q <= {sat_hi_q, sat_lo_q, 1'b0, trim_q};
            end
            for (int k = 0; k < 4; k++) begin
                if (i_reg_addr == `PDC_IDX_NUMER_BASE + 4'(2*k)) begin
                    rdata_q <= numer_q[k][15:8];
                end
                if (i_reg_addr == `PDC_IDX_NUMER_BASE + 4'(2*k+1)) begin
                    rdata_q <= numer_q[k][7:0];
                end
            end
            for (int k = 0; k < 3; k++) begin
                if (i_reg_addr == `PDC_IDX_DENOM_BASE + 4'(k)) begin
                    rdata_q <= denom_q[k];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Compensator
    // ------------------------------------------------------------------
    pdc_pwm_if pwm_bus ();
    pdc_err_t              err_q, e1_q, e2_q, e3_q;
    logic signed [12:0]    y1_q, y2_q, y3_q;
    pdc_duty_t             duty_q;
    pdc_duty_t             ceil_w;
    logic signed [23:0]    pc0, pc1, pc2, pc3;
    logic signed [20:0]    pb1, pb2, pb3;
    logic signed [27:0]    acc_w, lin_w;
    pdc_duty_t             duty_d;
    logic                  out_hi_w, out_lo_w;

    // Latest ADC error sample; the ADC sits on this clock
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            err_q <= '0;
        end else if (i_adc_valid) begin
            err_q <= i_adc_err;
        end
    end

    assign ceil_w   = {duty_ceiling_code, 6'h00}; // code/64 of 4096
    assign out_hi_w = $signed(err_q) > $signed(`PDC_SAT_WIN);
    assign out_lo_w = $signed(err_q) < -$signed(`PDC_SAT_WIN);

    // Third-order difference equation, all coefficients signed
    assign pc0 = numer_q[0] * err_q;
    assign pc1 = numer_q[1] * e1_q;
    assign pc2 = numer_q[2] * e2_q;
    assign pc3 = numer_q[3] * e3_q;
    assign pb1 = denom_q[0] * y1_q;
    assign pb2 = denom_q[1] * y2_q;
    assign pb3 = denom_q[2] * y3_q;
    assign acc_w = pc0 + pc1 + pc2 + pc3 - pb1 - pb2 - pb3;
    assign lin_w = (acc_w >>> `PDC_COEF_SHIFT) + $signed({23'h0, trim_q});

    // Saturation overrides the linear path; the clamp bounds both
    always_comb begin
        if (high_sat_feedforward_en && out_hi_w) begin
            duty_d = ceil_w;
        end else if (low_sat_feedforward_en && out_lo_w) begin
            duty_d = '0;
        end else if (lin_w < 28'sh0) begin
            duty_d = '0;
        end else if (lin_w > $signed({16'h0, ceil_w})) begin
            duty_d = ceil_w;
        end else begin
            duty_d = lin_w[11:0];
        end
    end

    // Once per period: new duty and shifted histories. The stored output
    // is the clamped duty, which keeps the integrator from winding up.
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            duty_q <= '0;
            e1_q   <= '0;
            e2_q   <= '0;
            e3_q   <= '0;
            y1_q   <= '0;
            y2_q   <= '0;
            y3_q   <= '0;
        end else if (pwm_bus.tick) begin
            duty_q <= duty_d;
            e1_q   <= err_q;
            e2_q   <= e1_q;
            e3_q   <= e2_q;
            y1_q   <= $signed({1'b0, duty_d});
            y2_q   <= y1_q;
            y3_q   <= y2_q;
        end
    end

    // Saturation status, refreshed each period
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            sat_hi_q <= 1'b0;
            sat_lo_q <= 1'b0;
        end else if (pwm_bus.tick) begin
            sat_hi_q <= high_sat_feedforward_en && out_hi_w;
            sat_lo_q <= low_sat_feedforward_en && out_lo_w && !out_hi_w;
        end
    end

    assign pwm_bus.duty = duty_q;

    pdc_pwm_gen u_gen (
        .i_clk  (i_clk),
        .i_rstn (i_rstn),
        .bus    (pwm_bus.gen),
        .o_pwm  (o_pwm)
    );

    // ------------------------------------------------------------------
    // Current share
    // ------------------------------------------------------------------
    logic       cs_s1_q, cs_s2_q, cs_oe_q, cs_out_q;
    logic [8:0] own_len_q, line_len_q;

    // Pull the line low for a time proportional to own current
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cs_oe_q  <= 1'b0;
            cs_out_q <= 1'b0;
        end else begin
            cs_oe_q  <= {pwm_bus.cnt, 8'h00} <
                        17'(i_iout * `PDC_PERIOD_CYC);
            cs_out_q <= 1'b0;
        end
    end

    // Line level comes from other units, so it is synchronised first
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cs_s1_q <= 1'b1;
            cs_s2_q <= 1'b1;
        end else begin
            cs_s1_q <= i_cs;
            cs_s2_q <= cs_s1_q;
        end
    end

    // Wired line shows the largest current; lag it and raise own duty
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            own_len_q  <= '0;
            line_len_q <= '0;
            trim_q     <= '0;
        end else if (pwm_bus.tick) begin
            own_len_q  <= '0;
            line_len_q <= '0;
            if (line_len_q > own_len_q + `PDC_SHARE_MARGIN) begin
                if (trim_q != `PDC_TRIM_MAX) trim_q <= trim_q + 5'h01;
            end else if (trim_q != 5'h00) begin
                trim_q <= trim_q - 5'h01;
            end
        end else begin
            if (cs_oe_q) own_len_q <= own_len_q + 9'h001;
            if (!cs_s2_q) line_len_q <= line_len_q + 9'h001;
        end
    end

    assign o_reg_rdata = rdata_q;
    assign o_cs_oe     = cs_oe_q;
    assign o_cs_out    = cs_out_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    ceil_cap_a: assert property (
        pwm_bus.tick |=> duty_q <= $past(ceil_w))
        else $error("Duty above ceiling");
    ceil_zero_a: assert property (
        pwm_bus.tick && duty_ceiling_code == 6'h00 |=> duty_q == 12'h000)
        else $error("Zero ceiling gave nonzero duty");
    hi_sat_a: assert property (
        pwm_bus.tick && high_sat_feedforward_en && out_hi_w
        |=> duty_q == $past(ceil_w))
        else $error("High saturation missed ceiling");
    lo_sat_a: assert property (
        pwm_bus.tick && low_sat_feedforward_en && out_lo_w && !out_hi_w
        |=> duty_q == 12'h000)
        else $error("Low saturation missed zero");
    // Tick at count 398, duty at 399, generator loads it at the wrap
    sat_one_cycle_a: assert property (
        pwm_bus.tick && high_sat_feedforward_en && out_hi_w
        |-> ##2 (pwm_bus.cnt == 9'h000
                 && u_gen.cur_q == $past(ceil_w, 2)))
        else $error("Saturated duty not applied within a period");
    linear_a: assert property (
        pwm_bus.tick && !out_hi_w && !out_lo_w && lin_w >= 28'sh0
        && lin_w <= $signed({16'h0, ceil_w}) |=> duty_q == $past(lin_w[11:0]))
        else $error("Linear duty not followed inside window");
    history_a: assert property (
        pwm_bus.tick |=> e1_q == $past(err_q) && e2_q == $past(e1_q)
        && y1_q == $signed({1'b0, duty_q}) && y2_q == $past(y1_q))
        else $error("Filter history not shifted");
    hold_a: assert property (
        !pwm_bus.tick |=> $stable(duty_q) && $stable(y1_q))
        else $error("Filter state moved between periods");
    numer_wr_a: assert property (
        i_reg_we && i_reg_addr == `PDC_IDX_NUMER_BASE
        |=> numer_q[0][15:8] == $past(i_reg_wdata))
        else $error("Numerator upper byte not written");
    limit_rd_a: assert property (
        i_reg_we && i_reg_addr == `PDC_IDX_LIMIT ##1 i_reg_addr == 4'h0
        |=> o_reg_rdata == $past(limit_q))
        else $error("Limit register readback wrong");
    share_a: assert property (
        pwm_bus.tick && line_len_q > own_len_q + `PDC_SHARE_MARGIN
        && trim_q != `PDC_TRIM_MAX |=> trim_q == $past(trim_q) + 5'h01)
        else $error("Share trim did not rise");

    hi_sat_c: cover property (pwm_bus.tick && sat_hi_q);
    lo_sat_c: cover property (pwm_bus.tick && sat_lo_q);
    linear_c: cover property (pwm_bus.tick && duty_q != 12'h000
        && duty_q < ceil_w);
    trim_c: cover property (trim_q == 5'h03);
endmodule // pdc_core

// >>> logic/pdc_pkg.sv
// Types shared by the PWM compensator core
package pdc_pkg;
    typedef logic signed [15:0] pdc_numer_t;
    typedef logic signed [7:0]  pdc_denom_t;
    typedef logic signed [7:0]  pdc_err_t;
    typedef logic        [11:0] pdc_duty_t;
    typedef logic        [8:0]  pdc_cnt_t;
endpackage

// >>> logic/pdc_pwm_gen.sv
// Switching-period counter and PWM comparator
`timescale 1ns/1ps
`include "pdc_cfg.svh"
module pdc_pwm_gen
    import pdc_pkg::*;
(
    input  wire logic i_clk,
    input  wire logic i_rstn,
    pdc_pwm_if.gen    bus,
    output logic      o_pwm
);
    pdc_cnt_t  cnt_q;
    pdc_duty_t cur_q;
    logic      tick_q;
    logic      pwm_q;

    // Period counter; duty is only taken at the wrap so no glitch mid-cycle
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt_q <= '0;
            cur_q <= '0;
        end else if (cnt_q == `PDC_PERIOD_CYC - 9'd1) begin
            cnt_q <= '0;
            cur_q <= bus.duty;
        end else begin
            cnt_q <= cnt_q + 9'd1;
        end
    end

    // Tick one cycle before the last count, so new duty is ready at wrap
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            tick_q <= 1'b0;
        end else begin
            tick_q <= (cnt_q == `PDC_PERIOD_CYC - 9'd3);
        end
    end

    // High while count/period is below duty/4096
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pwm_q <= 1'b0;
        end else begin
            pwm_q <= ({cnt_q, 12'h000} < 21'(cur_q * `PDC_PERIOD_CYC));
        end
    end

    assign bus.tick = tick_q;
    assign bus.cnt  = cnt_q;
    assign o_pwm    = pwm_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    zero_duty_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (cur_q == 12'h000) |=> !pwm_q)
        else $error("PWM high with zero duty");
    tick_gap_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        tick_q |=> !tick_q [*8])
        else $error("Tick repeated within a period");
endmodule // pdc_pwm_gen

// >>> logic/pdc_pwm_if.sv
// Carrier between the compensator and the PWM generator
`timescale 1ns/1ps
interface pdc_pwm_if;
    import pdc_pkg::*;
    pdc_duty_t duty;
    logic      tick;
    pdc_cnt_t  cnt;
    modport gen (input duty, output tick, output cnt);
    modport ctl (output duty, input tick, input cnt);
endinterface
